/* File: rtl/usart_sync.sv */
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module usart_sync
  import usart_sync_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link pins: input, output, output enable
  input wire link_pins_t pins_in,
  output link_pins_t pins_out,
  output link_pins_t pins_oe,
  // interrupt request
  output logic irq
);

  logic [7:0] irq_control_reg;
  logic [7:0] enables_reg;
  logic [7:0] prio_reg;
  logic [7:0] rx_ctrl_reg;
  logic [7:0] tx_ctrl_reg;
  logic [7:0] baud_divisor_reg;
  logic [7:0] tx_buffer_reg;
  logic [7:0] rx_buffer_reg;
  logic tx_full_reg;
  logic tx_flag_reg;
  logic [1:0] tx_clr_reg;
  logic rx_flag_reg;
  logic overrun_reg;
  logic rx_ninth_reg;
  shift_state_t state_reg;
  logic [8:0] shifter_reg;
  logic [3:0] bit_cnt_reg;
  logic [3:0] nbits_reg;
  logic [7:0] div_cnt_reg;
  logic ck_reg;
  logic dt_reg;
  link_pins_t sync1_reg;
  link_pins_t sync2_reg;
  link_pins_t sync3_reg;
  logic tx_enable_d_reg;

  function automatic logic [7:0] reg_index_ok(input logic [7:0] a);
    reg_index_ok = (a <= OFS_RX_BUFFER) && (a[1:0] == 2'b00) ? 8'h01 : 8'h00;
  endfunction

  // bus decode
  logic access;
  logic wr_en;
  logic rd_en;
  assign access = psel & penable & pready;
  assign wr_en = access & pwrite;
  assign rd_en = access & ~pwrite;

  // control bits
  logic serial_port_enable, sync_mode, master, tx_enable, tx9, rx9, single_rx_enable, continuous_rx_enable, active;
  assign serial_port_enable = rx_ctrl_reg[SERIAL_PORT_ENABLE_BIT];
  assign sync_mode = tx_ctrl_reg[CLOCKED_MODE_SELECT_BIT];
  assign master = tx_ctrl_reg[CLOCK_SOURCE_SELECT_BIT];
  assign tx_enable = tx_ctrl_reg[TX_ENABLE_BIT];
  assign tx9 = tx_ctrl_reg[TX_NINTH_ENABLE_BIT];
  assign rx9 = rx_ctrl_reg[RX_NINTH_ENABLE_BIT];
  assign single_rx_enable = rx_ctrl_reg[SINGLE_RX_ENABLE_BIT];
  assign continuous_rx_enable = rx_ctrl_reg[CONTINUOUS_RX_ENABLE_BIT];
  // asynchronous operation is not built here, so without the mode bit all stays idle
  assign active = serial_port_enable & sync_mode;

  // shift clock events
  logic tick, rise_ev, fall_ev, busy;
  assign busy = (state_reg != ST_IDLE);
  assign tick = (div_cnt_reg == baud_divisor_reg);
  always_comb begin
    if (master) begin
      rise_ev = tick & busy & ~ck_reg;
      fall_ev = tick & busy & ck_reg;
    end else begin
      rise_ev = busy & sync2_reg.ck & ~sync3_reg.ck;
      fall_ev = busy & ~sync2_reg.ck & sync3_reg.ck;
    end
  end

  // start and end of words
  logic tx_load, rx_start, rx_abort, last_bit;
  assign tx_load = active & tx_enable & tx_full_reg & (state_reg == ST_IDLE);
  assign rx_start = active & (single_rx_enable | continuous_rx_enable) & ~overrun_reg & (state_reg == ST_IDLE)
                    & ~tx_load;
  assign rx_abort = (state_reg == ST_RX) & ~(single_rx_enable | continuous_rx_enable);
  assign last_bit = fall_ev & (bit_cnt_reg == nbits_reg - BIT_ONE);
  logic rx_done;
  assign rx_done = (state_reg == ST_RX) & last_bit;

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // apb answer: one access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & (reg_index_ok(paddr) == 8'h00);
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          OFS_IRQ_CONTROL: prdata <= {24'h000000, irq_control_reg};
          OFS_PERIPH_FLAGS: prdata <= {26'h0000000, rx_flag_reg, tx_flag_reg, 4'h0};
          OFS_PERIPH_ENABLES: prdata <= {24'h000000, enables_reg};
          OFS_PERIPH_PRIO: prdata <= {24'h000000, prio_reg};
          OFS_RX_STATUS_CONTROL: prdata <= {24'h000000, rx_ctrl_reg[7:3], 1'b0,
                                            overrun_reg, rx_ninth_reg};
          OFS_TX_BUFFER: prdata <= {24'h000000, tx_buffer_reg};
          OFS_TX_STATUS_CONTROL: prdata <= {24'h000000, tx_ctrl_reg[7:4], 1'b0,
                                            tx_ctrl_reg[2], ~(state_reg == ST_TX),
                                            tx_ctrl_reg[0]};
          OFS_BAUD_DIVISOR: prdata <= {24'h000000, baud_divisor_reg};
          OFS_RX_BUFFER: prdata <= {24'h000000, rx_buffer_reg};
          default: prdata <= '0;
        endcase
      end
    end
  end

  // plain control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_control_reg <= RST_ZERO;
      enables_reg <= RST_ZERO;
      prio_reg <= RST_ZERO;
      tx_ctrl_reg <= RST_TX_STATUS_CONTROL;
      baud_divisor_reg <= RST_ZERO;
    end else if (wr_en) begin
      case (paddr)
        OFS_IRQ_CONTROL: irq_control_reg <= pwdata[7:0] & 8'hC0;
        OFS_PERIPH_ENABLES: enables_reg <= pwdata[7:0] & 8'h30;
        OFS_PERIPH_PRIO: prio_reg <= pwdata[7:0];
        OFS_TX_STATUS_CONTROL: tx_ctrl_reg <= pwdata[7:0] & 8'hF5;
        OFS_BAUD_DIVISOR: baud_divisor_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // receive control; single_rx_enable is cleared by hardware after one word unless continuous_rx_enable is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ctrl_reg <= RST_ZERO;
    end else begin
      if (wr_en && paddr == OFS_RX_STATUS_CONTROL) begin
        rx_ctrl_reg <= pwdata[7:0] & 8'hF8;
      end else if (rx_done && !continuous_rx_enable) begin
        rx_ctrl_reg[SINGLE_RX_ENABLE_BIT] <= 1'b0;
      end
    end
  end

  // transmit buffer and its empty flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buffer_reg <= RST_ZERO;
      tx_full_reg <= 1'b0;
      tx_clr_reg <= 2'b00;
      tx_flag_reg <= 1'b0;
      tx_enable_d_reg <= 1'b0;
    end else begin
      tx_enable_d_reg <= tx_enable;
      tx_clr_reg <= {tx_clr_reg[0], wr_en && paddr == OFS_TX_BUFFER};
      if (wr_en && paddr == OFS_TX_BUFFER) begin
        tx_buffer_reg <= pwdata[7:0];
        tx_full_reg <= 1'b1;
      end else if (tx_load) begin
        tx_full_reg <= 1'b0;
      end
      // set wins over the delayed clear; flag writes from software are ignored
      if (tx_load || (tx_enable && !tx_enable_d_reg && !tx_full_reg)) begin
        tx_flag_reg <= 1'b1;
      end else if (tx_clr_reg[1] && tx_full_reg) begin
        tx_flag_reg <= 1'b0;
      end
    end
  end

  // shift engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      shifter_reg <= '0;
      bit_cnt_reg <= '0;
      nbits_reg <= WORD_BITS_8;
      dt_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          bit_cnt_reg <= '0;
          if (tx_load) begin
            state_reg <= ST_TX;
            shifter_reg <= {tx_ctrl_reg[TX_NINTH_VALUE_BIT], tx_buffer_reg};
            nbits_reg <= tx9 ? WORD_BITS_9 : WORD_BITS_8;
            dt_reg <= tx_buffer_reg[0];
          end else if (rx_start) begin
            state_reg <= ST_RX;
            nbits_reg <= rx9 ? WORD_BITS_9 : WORD_BITS_8;
          end
        end
        ST_TX: begin
          if (rise_ev && bit_cnt_reg != 4'h0) begin
            dt_reg <= shifter_reg[bit_cnt_reg];
          end
          if (last_bit) begin
            state_reg <= ST_IDLE;
          end else if (fall_ev) begin
            bit_cnt_reg <= bit_cnt_reg + BIT_ONE;
          end
        end
        ST_RX: begin
          if (fall_ev) begin
            shifter_reg[bit_cnt_reg] <= sync2_reg.dt;
            bit_cnt_reg <= bit_cnt_reg + BIT_ONE;
          end
          if (last_bit || rx_abort || !active) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // master shift clock divider; idles low between words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= '0;
      ck_reg <= 1'b0;
    end else if (!busy || !master) begin
      div_cnt_reg <= '0;
      ck_reg <= 1'b0;
    end else if (tick) begin
      div_cnt_reg <= '0;
      ck_reg <= ~ck_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // received word, full flag and overrun
  logic rx_word_in;
  assign rx_word_in = rx_done;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buffer_reg <= RST_ZERO;
      rx_ninth_reg <= 1'b0;
      rx_flag_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      if (rx_word_in && !rx_flag_reg) begin
        rx_buffer_reg <= {sync2_reg.dt, shifter_reg[6:0]}; // nbits 8 case
        if (nbits_reg == WORD_BITS_9) begin
          rx_buffer_reg <= shifter_reg[7:0];
          rx_ninth_reg <= sync2_reg.dt;
        end
      end
      // a word that lands in the read cycle keeps the full flag set (set wins) but is not loaded into the buffer
      if (rx_word_in) begin
        rx_flag_reg <= 1'b1;
      end else if (rd_en && paddr == OFS_RX_BUFFER) begin
        rx_flag_reg <= 1'b0;
      end
      if (!continuous_rx_enable) begin
        overrun_reg <= 1'b0;
      end else if (rx_word_in && rx_flag_reg) begin
        overrun_reg <= 1'b1;
      end
    end
  end

  // pin drive and interrupt, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_out <= '0;
      pins_oe <= '0;
      irq <= 1'b0;
    end else begin
      pins_out.ck <= ck_reg;
      pins_out.dt <= dt_reg;
      pins_oe.ck <= active & master;
      pins_oe.dt <= active & (state_reg == ST_TX);
      irq <= irq_control_reg[GLOBAL_IRQ_ENABLE_BIT] & irq_control_reg[PERIPHERAL_IRQ_ENABLE_BIT]
             & ((rx_flag_reg & enables_reg[RX_FULL_BIT])
             | (tx_flag_reg & enables_reg[TX_EMPTY_BIT]));
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  half_duplex_a: assert property (pins_oe.dt |-> state_reg != ST_RX)
    else $error("data driven during reception");
  master_clock_a: assert property (pins_oe.ck |-> $past(master) && $past(active))
    else $error("clock driven outside master mode");
  no_early_load_a: assert property ((state_reg == ST_TX) && !last_bit |=> state_reg == ST_TX)
    else $error("shifter left before last bit");
  load_sets_flag_a: assert property (tx_load |=> tx_flag_reg && !tx_full_reg)
    else $error("buffer move did not set empty flag");
  flag_clear_delay_a: assert property (
      wr_en && paddr == OFS_TX_BUFFER && tx_flag_reg && state_reg != ST_IDLE
      |=> tx_flag_reg ##1 tx_flag_reg ##1 !tx_flag_reg)
    else $error("empty flag clear timing wrong");
  sw_flag_clear_a: assert property (
      wr_en && paddr == OFS_PERIPH_FLAGS && tx_flag_reg && !tx_clr_reg[1] |=> tx_flag_reg)
    else $error("software cleared empty flag");
  shifter_empty_a: assert property (
      rd_en && paddr == OFS_TX_STATUS_CONTROL && $past(state_reg == ST_TX)
      |-> prdata[TX_SHIFTER_EMPTY_BIT] == 1'b0)
    else $error("shifter empty shown while busy");
  sample_fall_a: assert property (
      state_reg == ST_RX && $changed(bit_cnt_reg) && bit_cnt_reg != 4'h0 |-> $past(fall_ev))
    else $error("receive sample off the falling edge");
  single_stop_a: assert property (rx_done && !continuous_rx_enable |=> !single_rx_enable ##1 state_reg == ST_IDLE)
    else $error("single reception did not stop");
  rx_flag_set_a: assert property (rx_done |=> rx_flag_reg)
    else $error("received word did not set full flag");
  error_clear_a: assert property (!continuous_rx_enable |=> !overrun_reg)
    else $error("overrun not cleared by disabling reception");

  tx_word_c: cover property (state_reg == ST_TX ##1 state_reg == ST_IDLE);
  rx_word_c: cover property (rx_done);
  overrun_c: cover property ($rose(overrun_reg));

endmodule

/* File: rtl/usart_sync_pkg.sv */
package usart_sync_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] OFS_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PERIPH_FLAGS = 8'h04;
  localparam logic [7:0] OFS_PERIPH_ENABLES = 8'h08;
  localparam logic [7:0] OFS_PERIPH_PRIO = 8'h0C;
  localparam logic [7:0] OFS_RX_STATUS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_TX_BUFFER = 8'h14;
  localparam logic [7:0] OFS_TX_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h1C;
  localparam logic [7:0] OFS_RX_BUFFER = 8'h20;

  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TX_STATUS_CONTROL = 8'h02;

  // irq_control fields
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  // peripheral flags / enables fields
  localparam int RX_FULL_BIT = 5;
  localparam int TX_EMPTY_BIT = 4;
  // rx_status_control fields
  localparam int SERIAL_PORT_ENABLE_BIT = 7;
  localparam int RX_NINTH_ENABLE_BIT = 6;
  localparam int SINGLE_RX_ENABLE_BIT = 5;
  localparam int CONTINUOUS_RX_ENABLE_BIT = 4;
  localparam int ADDRESS_DETECT_BIT = 3;
  localparam int FRAMING_ERROR_BIT = 2;
  localparam int OVERRUN_ERROR_BIT = 1;
  localparam int RX_NINTH_VALUE_BIT = 0;
  // tx_status_control fields
  localparam int CLOCK_SOURCE_SELECT_BIT = 7;
  localparam int TX_NINTH_ENABLE_BIT = 6;
  localparam int TX_ENABLE_BIT = 5;
  localparam int CLOCKED_MODE_SELECT_BIT = 4;
  localparam int HIGH_SPEED_BIT = 2;
  localparam int TX_SHIFTER_EMPTY_BIT = 1;
  localparam int TX_NINTH_VALUE_BIT = 0;

  // word lengths in bits
  localparam logic [3:0] WORD_BITS_8 = 4'h8;
  localparam logic [3:0] WORD_BITS_9 = 4'h9;
  localparam logic [3:0] BIT_ONE = 4'h1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TX = 2'b01,
    ST_RX = 2'b10
  } shift_state_t;

  typedef struct packed {
    logic ck;
    logic dt;
  } link_pins_t;

endpackage

/* File: tb/sync_peer.sv */
`timescale 1ns/1ns
module sync_peer (
  // clock
  input wire logic pclk,
  // link levels and device data enable
  input wire logic ck,
  input wire logic dt,
  input wire logic dev_dt_oe,
  // word offered to the device, word length, offer enable
  input wire logic [8:0] feed_word,
  input wire logic [3:0] nbits,
  input wire logic armed,
  // peer drive, filler level, observations
  output logic dt_drive,
  output logic noise,
  output logic [8:0] got_word,
  output int got_count,
  output int fed_count
);
  logic ck_q = 1'b0;
  logic dt_q = 1'b0;
  logic oe_q = 1'b0;
  logic [8:0] acc = 9'h000;
  int bit_idx = 0;
  int feed_idx = 0;

  initial begin
    noise = 1'b0;
    got_word = 9'h000;
    got_count = 0;
    fed_count = 0;
  end

  // an unarmed line shows a toggling filler, never a held value
  assign dt_drive = armed ? feed_word[feed_idx] : noise;

  always @(posedge pclk) begin
    noise <= ~noise;
    ck_q <= ck;
    dt_q <= dt;
    oe_q <= dev_dt_oe;
    if (ck_q && !ck) begin
      // levels set up before the fall count, since the device may release data with it
      if (oe_q) begin
        // device data taken on the falling shift clock edge
        acc[bit_idx] = dt_q;
        if (bit_idx == nbits - 1) begin
          got_word <= acc;
          got_count <= got_count + 1;
          acc = 9'h000;
          bit_idx = 0;
        end else begin
          bit_idx = bit_idx + 1;
        end
      end else if (armed) begin
        // next bit only once the device has sampled this one
        if (feed_idx == nbits - 1) begin
          feed_idx = 0;
          fed_count <= fed_count + 1;
        end else begin
          feed_idx = feed_idx + 1;
        end
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench
  import usart_sync_pkg::*;
;
  logic pclk;
  logic presetn;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  link_pins_t pins_in;
  link_pins_t pins_out;
  link_pins_t pins_oe;
  logic irq;
  logic dt_drive;
  logic [8:0] feed_word;
  logic [3:0] nbits;
  logic armed;
  logic [8:0] got_word;
  int got_count;
  int fed_count;
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] rdat;
  logic rerr;

  // wire level comes from whichever side enables its driver; an undriven clock rests low
  assign pins_in = {(pins_oe.ck ? pins_out.ck : 1'b0),
                    (pins_oe.dt ? pins_out.dt : dt_drive)};

  usart_sync i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out),
    .pins_oe(pins_oe), .irq(irq));

  sync_peer i_peer (.pclk(pclk), .ck(pins_in.ck), .dt(pins_in.dt),
    .dev_dt_oe(pins_oe.dt), .feed_word(feed_word), .nbits(nbits), .armed(armed),
    .dt_drive(dt_drive), .noise(), .got_word(got_word), .got_count(got_count),
    .fed_count(fed_count));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic hang(input int n, input int lim);
    if (n >= lim) begin
      err_count++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // the request is held until pready is seen high at a rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    hang(n, 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, rdat, rerr);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(a, 1'b0, 8'h00, rdat, rerr);
    check({1'b0, rdat[7:0] & m}, {1'b0, e});
  endtask

  task automatic wait_bit(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin
      bus(a, 1'b0, 8'h00, rdat, rerr);
      n++;
    end while (rdat[b] !== 1'b1 && n < 400);
    hang(n, 400);
  endtask

  task automatic wait_link(input int t);
    int n;
    n = 0;
    while (got_count + fed_count < t && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    hang(n, 2000);
  endtask

  // outputs are registered behind the register state, so let them land
  task automatic settle();
    repeat (3) @(negedge pclk);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    feed_word = 9'h000;
    nbits = 4'h9;
    armed = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd_chk(8'(i * 4), 8'hFF, (i == 6) ? 8'h02 : 8'h00);
    end
    bus(8'h24, 1'b0, 8'h00, rdat, rerr);
    check({8'h00, rerr}, 9'h001);
    wr(OFS_BAUD_DIVISOR, 8'h03);
    wr(OFS_RX_STATUS_CONTROL, 8'h80);
    settle();
    check({8'h00, pins_oe.ck}, 9'h000);
    wr(OFS_TX_STATUS_CONTROL, 8'h90);
    settle();
    check({8'h00, pins_oe.ck}, 9'h001);
    wr(OFS_IRQ_CONTROL, 8'hC0);
    wr(OFS_TX_STATUS_CONTROL, 8'hF1);
    rd_chk(OFS_PERIPH_FLAGS, 8'h10, 8'h10);
    wr(OFS_PERIPH_FLAGS, 8'h00);
    rd_chk(OFS_PERIPH_FLAGS, 8'h10, 8'h10);
    settle();
    check({8'h00, irq}, 9'h000);
    wr(OFS_PERIPH_ENABLES, 8'h10);
    settle();
    check({8'h00, irq}, 9'h001);
    feed_word <= 9'h15A;
    armed <= 1'b1;
    wr(OFS_TX_BUFFER, 8'hA5);
    settle();
    rd_chk(OFS_PERIPH_FLAGS, 8'h10, 8'h10);
    wr(OFS_TX_BUFFER, 8'h3C);
    // receive asked for while transmit is still busy
    wr(OFS_RX_STATUS_CONTROL, 8'hE0);
    rd_chk(OFS_PERIPH_FLAGS, 8'h10, 8'h00);
    rd_chk(OFS_TX_STATUS_CONTROL, 8'h02, 8'h00);
    wait_link(1);
    check(got_word, 9'h1A5);
    wait_link(2);
    check(got_word, 9'h13C);
    check(9'(fed_count), 9'h000);
    wait_bit(OFS_TX_STATUS_CONTROL, TX_SHIFTER_EMPTY_BIT);
    rd_chk(OFS_PERIPH_FLAGS, 8'h10, 8'h10);
    wr(OFS_PERIPH_ENABLES, 8'h20);
    wait_link(3);
    wait_bit(OFS_PERIPH_FLAGS, RX_FULL_BIT);
    settle();
    check({8'h00, irq}, 9'h001);
    rd_chk(OFS_RX_STATUS_CONTROL, 8'hFF, 8'hC1);
    rd_chk(OFS_RX_BUFFER, 8'hFF, 8'h5A);
    rd_chk(OFS_PERIPH_FLAGS, 8'h20, 8'h00);
    repeat (100) @(posedge pclk);
    check(9'(fed_count), 9'h001);
    nbits <= 4'h8;
    feed_word <= 9'h0C3;
    wr(OFS_RX_STATUS_CONTROL, 8'hB0);
    wait_link(4);
    wait_bit(OFS_PERIPH_FLAGS, RX_FULL_BIT);
    rd_chk(OFS_RX_BUFFER, 8'hFF, 8'hC3);
    wait_link(6);
    rd_chk(OFS_RX_STATUS_CONTROL, 8'h02, 8'h02);
    wr(OFS_RX_STATUS_CONTROL, 8'h80);
    rd_chk(OFS_RX_STATUS_CONTROL, 8'h02, 8'h00);
    armed <= 1'b0;
    wr(OFS_TX_STATUS_CONTROL, 8'h10);
    settle();
    check({8'h00, pins_oe.ck}, 9'h000);
    report_and_stop();
  end
endmodule
